//--- hw/sdio_pkg.sv
// Shared constants and types for the serial video port mode and path control
`default_nettype none
package sdio_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_INT_MASK = 4'hC;
    localparam int CTRL_LOCK_CD_BIT = 0;
    localparam int CTRL_SPLITTER_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int NUM_EVENTS = 3;
    localparam int EV_CARRIER_UP = 0;
    localparam int EV_CARRIER_DOWN = 1;
    localparam int EV_MODE_CHANGE = 2;
    localparam logic [NUM_EVENTS-1:0] INT_MASK_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SYNC_W = 11;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 11'h000;

    typedef enum logic [1:0] {
        LVL_L,
        LVL_R,
        LVL_F,
        LVL_H
    } sdio_level_t;

    typedef struct packed {
        logic splitter_mode;
        logic lock_shows_carrier;
    } sdio_ctrl_t;

    typedef struct packed {
        logic line_eq_en;
        logic host_eq_en;
        logic line_drv_en;
        logic aux_out_en;
        logic host_out_en;
        logic splitter_en;
        logic carrier_det_en;
    } sdio_path_t;

    localparam sdio_path_t PATH_OFF = '{default: 1'b0};
endpackage : sdio_pkg
`default_nettype wire

//--- hw/sdio_sync.sv
// Three-stage pin synchroniser; output follows once stages two and three agree
`default_nettype none
module sdio_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sdio_pkg::SYNC_W-1:0] pin_in,
    output logic [sdio_pkg::SYNC_W-1:0] pin_out,
    output logic settled
);
    import sdio_pkg::*;

    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
    logic [SYNC_W-1:0] stage3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= SYNC_RESET;
            stage2 <= SYNC_RESET;
            stage3 <= SYNC_RESET;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Per bit, a change counts only when the two later stages agree
    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_out[i] <= 1'b0;
                end else if (stage2[i] == stage3[i]) begin
                    pin_out[i] <= stage3[i];
                end
            end
        end
    endgenerate

    // Pipeline filled with real pin values, first output then valid
    logic [1:0] fill;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill <= 2'h0;
            settled <= 1'b0;
        end else begin
            if (fill != 2'h3) begin
                fill <= fill + 2'h1;
            end
            settled <= (fill == 2'h3);
        end
    end
endmodule : sdio_sync
`default_nettype wire

//--- hw/sdio_ctrl.sv
// Mode, path, power and carrier-detect control with AXI4-Lite registers
//
// Function
// - Direction low: line-input mode, line input used, host output on, line driver off.
// - Direction high: line-drive mode, host input driven to line, aux allowed, line EQ off.
// - Any direction change after power-up resets the recovery loop.
// - Line-input: host select ignored; loop-through low adds reclocked aux copy.
// - Line-drive: loop-through low enables aux driver; host select low enables loop-back.
// - Carrier detector watches the selected input; normal operation while above threshold.
// - No signal enters power save; returning signal leaves it automatically.
// - Enable low forces power-down regardless of direction, inputs ignored.
// - Power save keeps carrier detector and serial interface running.
// - Power-down keeps only the serial interface; detector off.
// - Carrier status readable; optionally shown on lock pin.
// - Line-input mode offers register-selected reduced launch amplitude setting.
// - Line-input mode enables line equalizer, powers down host-input equalizer.
// - Each select pin decodes to L, R, F or H from three comparators.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`default_nettype none
module sdio_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [sdio_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [sdio_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sdio_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [sdio_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins: comparator outputs at 0.2, 0.5, 0.8 of supply, bit 0 lowest
    input wire logic [2:0] direction_select,
    input wire logic [2:0] host_output_select,
    input wire logic [2:0] loopthru_output_select,
    input wire logic enable_pin,
    input wire logic line_port_carrier,
    input wire logic host_input_carrier,
    // Control outputs
    output sdio_pkg::sdio_path_t path,
    output logic line_drive_mode,
    output logic cdr_reset,
    output logic power_save,
    output logic power_down,
    output logic carrier_present_flag_n,
    output logic irq
);
    import sdio_pkg::*;

    // Thermometer code from the three comparators to a level
    function automatic sdio_level_t decode_level(input logic [2:0] cmp);
        return cmp[2] ? LVL_H : (cmp[1] ? LVL_F : (cmp[0] ? LVL_R : LVL_L));
    endfunction : decode_level

    // Float reads high, so an open pin keeps the outputs disabled
    function automatic logic level_high(input sdio_level_t lvl);
        return (lvl == LVL_H) || (lvl == LVL_F);
    endfunction : level_high

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
        return (addr == OFF_CTRL) || (addr == OFF_STATUS) || (addr == OFF_INT_STATUS) || (addr == OFF_INT_MASK);
    endfunction : reg_mapped

    // ---------------- Pin synchronisation ----------------
    logic [SYNC_W-1:0] pins_sync;
    logic pins_settled;

    sdio_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({direction_select, host_output_select, loopthru_output_select,
            enable_pin, line_port_carrier}),
        .pin_out(pins_sync),
        .settled(pins_settled)
    );

    logic host_carrier_sync;
    logic [2:0] host_carrier_pipe;

    // Same three-stage filter for the second detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_carrier_pipe <= 3'h0;
            host_carrier_sync <= 1'b0;
        end else begin
            host_carrier_pipe <= {host_carrier_pipe[1:0], host_input_carrier};
            if (host_carrier_pipe[1] == host_carrier_pipe[2]) begin
                host_carrier_sync <= host_carrier_pipe[2];
            end
        end
    end

    sdio_level_t dir_level;
    sdio_level_t host_sel_level;
    sdio_level_t loop_sel_level;
    logic enabled;
    logic line_carrier_sync;

    always_comb begin
        dir_level = decode_level(pins_sync[10:8]);
        host_sel_level = decode_level(pins_sync[7:5]);
        loop_sel_level = decode_level(pins_sync[4:2]);
        enabled = pins_sync[1];
        line_carrier_sync = pins_sync[0];
    end

    // ---------------- Mode and recovery reset ----------------
    logic dir_high;
    logic dir_prev;
    logic dir_primed;
    logic mode_changed;
    logic mode_next;

    assign dir_high = level_high(dir_level);
    assign mode_next = pins_settled ? dir_high : line_drive_mode;
    assign mode_changed = dir_primed && (dir_high != dir_prev);

    // Strapped level taken as baseline; only later changes reset the loop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_prev <= 1'b0;
            dir_primed <= 1'b0;
            cdr_reset <= 1'b0;
        end else begin
            if (pins_settled) begin
                dir_prev <= dir_high;
                dir_primed <= 1'b1;
            end
            cdr_reset <= mode_changed;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_drive_mode <= 1'b0;
        end else if (pins_settled) begin
            line_drive_mode <= dir_high;
        end
    end

    // ---------------- Carrier detect and power state ----------------
    logic carrier;
    logic carrier_prev;

    // Detector off in power-down, so carrier reads absent there
    always_comb begin
        carrier = 1'b0;
        if (pins_settled && enabled) begin
            carrier = mode_next ? host_carrier_sync : line_carrier_sync;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_down <= 1'b1;
            power_save <= 1'b0;
            carrier_prev <= 1'b0;
        end else begin
            power_down <= !(pins_settled && enabled);
            power_save <= pins_settled && enabled && !carrier;
            carrier_prev <= carrier;
        end
    end

    // ---------------- Data path enables ----------------
    sdio_ctrl_t ctrl;
    sdio_path_t next_path;
    logic active;

    assign active = pins_settled && enabled && carrier;

    always_comb begin
        next_path = PATH_OFF;
        // Detector stays up in power save, drops in power-down
        next_path.carrier_det_en = pins_settled && enabled;
        if (active) begin
            if (!mode_next) begin
                next_path.line_eq_en = 1'b1;
                next_path.host_eq_en = 1'b0;
                next_path.line_drv_en = 1'b0;
                next_path.host_out_en = 1'b1;
                next_path.aux_out_en = !level_high(loop_sel_level);
                next_path.splitter_en = ctrl.splitter_mode;
            end else begin
                next_path.line_eq_en = 1'b0;
                next_path.host_eq_en = 1'b1;
                next_path.line_drv_en = 1'b1;
                next_path.aux_out_en = !level_high(loop_sel_level);
                next_path.host_out_en = !level_high(host_sel_level);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            path <= PATH_OFF;
        end else begin
            path <= next_path;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carrier_present_flag_n <= 1'b1;
        end else begin
            // Pin idles high unless software routes carrier status to it
            carrier_present_flag_n <= !(ctrl.lock_shows_carrier && carrier);
        end
    end

    // ---------------- Interrupts ----------------
    logic [NUM_EVENTS-1:0] int_status;
    logic [NUM_EVENTS-1:0] int_mask;
    logic [NUM_EVENTS-1:0] events;
    logic [NUM_EVENTS-1:0] w1c;

    always_comb begin
        events = '0;
        events[EV_CARRIER_UP] = carrier && !carrier_prev;
        events[EV_CARRIER_DOWN] = !carrier && carrier_prev;
        events[EV_MODE_CHANGE] = mode_changed;
    end

    // ---------------- AXI4-Lite write ----------------
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= reg_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only byte lane 0 carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
            int_mask <= INT_MASK_RESET;
        end else if (do_write && w_strb[0]) begin
            if (aw_addr == OFF_CTRL) begin
                ctrl.lock_shows_carrier <= w_data[CTRL_LOCK_CD_BIT];
                ctrl.splitter_mode <= w_data[CTRL_SPLITTER_BIT];
            end
            if (aw_addr == OFF_INT_MASK) begin
                int_mask <= w_data[NUM_EVENTS-1:0];
            end
        end
    end

    assign w1c = (do_write && w_strb[0] && aw_addr == OFF_INT_STATUS) ? w_data[NUM_EVENTS-1:0] : '0;

    // New event wins over a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_status <= '0;
        end else begin
            int_status <= (int_status & ~w1c) | events;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
        end
    end

    // ---------------- AXI4-Lite read ----------------
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        unique case (s_axi_araddr)
            OFF_CTRL: begin
                next_rdata[CTRL_LOCK_CD_BIT] = ctrl.lock_shows_carrier;
                next_rdata[CTRL_SPLITTER_BIT] = ctrl.splitter_mode;
            end
            OFF_STATUS: begin
                next_rdata[0] = carrier;
                next_rdata[1] = line_drive_mode;
                next_rdata[2] = power_save;
                next_rdata[3] = power_down;
                next_rdata[5:4] = dir_level;
                next_rdata[7:6] = host_sel_level;
                next_rdata[9:8] = loop_sel_level;
            end
            OFF_INT_STATUS: next_rdata[NUM_EVENTS-1:0] = int_status;
            OFF_INT_MASK: next_rdata[NUM_EVENTS-1:0] = int_mask;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : sdio_ctrl
`default_nettype wire

//--- tb/sdio_ctrl_checker.sv
// Checker for mode, path, power and bus answer behaviour
`default_nettype none
module sdio_ctrl_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire sdio_pkg::sdio_path_t path,
    input wire logic line_drive_mode,
    input wire logic cdr_reset,
    input wire logic power_save,
    input wire logic power_down,
    input wire logic carrier_present_flag_n
);
    timeunit 1ns;
    timeprecision 1ns;
    import sdio_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_pd_path_off: assert property (power_down |-> path == PATH_OFF)
        else $error("path active in power-down");
    a_save_det_only: assert property (power_save |-> path == sdio_path_t'(7'h01))
        else $error("power save path wrong");
    a_line_in_path: assert property (!power_down && !power_save && !line_drive_mode |->
        path.line_eq_en && path.host_out_en && !path.line_drv_en && !path.host_eq_en)
        else $error("line-input path wrong");
    a_line_drv_path: assert property (!power_down && !power_save && line_drive_mode |->
        !path.line_eq_en && path.line_drv_en && path.host_eq_en && !path.splitter_en)
        else $error("line-drive path wrong");
    a_cdr_one_cycle: assert property (cdr_reset |=> !cdr_reset)
        else $error("recovery reset longer than one cycle");
    // Mode and reset pulse land on the same edge; two back still holds the old mode
    a_cdr_on_change: assert property (cdr_reset |-> line_drive_mode != $past(line_drive_mode, 2))
        else $error("recovery reset without mode change");
    a_flag_off_pd: assert property (power_down && $past(power_down) |-> carrier_present_flag_n)
        else $error("carrier flag shown while powered down");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
endmodule : sdio_ctrl_checker
`default_nettype wire

//--- tb/sdio_link_model.sv
// Far side: cable and host link signal presence
`default_nettype none
module sdio_link_model (
    input wire logic aclk,
    input wire logic line_on,
    input wire logic host_on,
    output logic line_port_carrier,
    output logic host_input_carrier
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        line_port_carrier = 1'h0;
        host_input_carrier = 1'h0;
    end
    // Presence moves only after an edge, as a real source would
    always @(posedge aclk) begin
        line_port_carrier <= line_on;
        host_input_carrier <= host_on;
    end
endmodule : sdio_link_model
`default_nettype wire

//--- tb/sdio_ctrl_tb_top.sv
// Bench: pin and register scenarios for mode and path control
`default_nettype none
module sdio_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sdio_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] direction_select = 3'h0, host_output_select = 3'h0, loopthru_output_select = 3'h7;
    logic enable_pin = 1'h1, line_on = 1'h0, host_on = 1'h0;
    logic line_port_carrier, host_input_carrier, line_drive_mode, cdr_reset;
    logic power_save, power_down, carrier_present_flag_n, irq;
    sdio_path_t path;
    int mismatches = 0, tests_run = 0, cyc = 0, cdr_count = 0;

    sdio_ctrl dut (.*);
    sdio_link_model link (.*);

    initial begin
        forever #25 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cdr_reset === 1'h1) begin
            cdr_count <= cdr_count + 1;
        end
        if (cyc == 4000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic pth(input logic [6:0] e);
        repeat (10) @(posedge aclk);
        chk("path", {25'h0, path}, {25'h0, e});
    endtask : pth

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'h1) begin
                aw_ok = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w_ok && s_axi_wready === 1'h1) begin
                w_ok = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        s_axi_rready <= 1'h0;
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
    endtask : axi_rd

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        axi_rd(OFF_INT_MASK, RESP_OKAY);
        chk("mask", rd, 32'h0);
        pth(7'h01);
        line_on <= 1'h1;
        pth(7'h45);
        axi_rd(OFF_STATUS, RESP_OKAY);
        chk("status", rd, 32'h301);
        loopthru_output_select <= 3'h0;
        host_output_select <= 3'h7;
        pth(7'h4D);
        axi_wr(OFF_CTRL, 32'h2, RESP_OKAY);
        pth(7'h4F);
        axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
        pth(7'h4D);
        chk("flag", {31'h0, carrier_present_flag_n}, 32'h0);
        axi_wr(OFF_INT_MASK, 32'h7, RESP_OKAY);
        axi_wr(OFF_INT_STATUS, 32'h7, RESP_OKAY);
        // Board toggles the strap after power-up
        direction_select <= 3'h7;
        pth(7'h01);
        chk("mode", {31'h0, line_drive_mode}, 32'h1);
        chk("cdr", cdr_count, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        axi_rd(OFF_INT_STATUS, RESP_OKAY);
        chk("ev", rd & 32'h4, 32'h4);
        host_on <= 1'h1;
        pth(7'h39);
        host_output_select <= 3'h0;
        pth(7'h3D);
        loopthru_output_select <= 3'h3;
        pth(7'h35);
        axi_rd(OFF_STATUS, RESP_OKAY);
        chk("status", rd, 32'h233);
        axi_wr(OFF_INT_STATUS, 32'h7, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("irq", {31'h0, irq}, 32'h0);
        axi_wr(OFF_INT_MASK, 32'h0, RESP_OKAY);
        direction_select <= 3'h0;
        pth(7'h45);
        chk("cdr", cdr_count, 32'h2);
        chk("irq", {31'h0, irq}, 32'h0);
        axi_wr(OFF_INT_MASK, 32'h4, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("irq", {31'h0, irq}, 32'h1);
        axi_wr(OFF_INT_STATUS, 32'h4, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("irq", {31'h0, irq}, 32'h0);
        enable_pin <= 1'h0;
        pth(7'h00);
        chk("flag", {31'h0, carrier_present_flag_n}, 32'h1);
        axi_rd(OFF_STATUS, RESP_OKAY);
        chk("status", rd & 32'hF, 32'h8);
        enable_pin <= 1'h1;
        pth(7'h45);
        chk("cdr", cdr_count, 32'h2);
        // Hole in the map between status and events
        axi_wr(4'h6, 32'hFFFFFFFF, RESP_SLVERR);
        axi_rd(4'h6, RESP_SLVERR);
        chk("unmapped", rd, 32'h0);
        line_on <= 1'h0;
        pth(7'h01);
        chk("save", {31'h0, power_save}, 32'h1);
        report_and_stop();
    end
endmodule : sdio_ctrl_tb_top

bind sdio_ctrl sdio_ctrl_checker chk_i (.*);
`default_nettype wire
